//--- hw/cifp_irq_fault_cfg.sv
// Interrupt pin, sticky flag and fault power-down configuration block.
`timescale 1ns/1ps

module cifp_irq_fault_cfg #(
    parameter int unsigned PULSE_CYCLES  = cifp_pkg::IRQ_PULSE_CYCLES,
    parameter int unsigned PERIOD_CYCLES = cifp_pkg::IRQ_PERIOD_CYCLES
) (
    // Clock and reset.
    input  wire logic       clk,
    input  wire logic       reset,
    // Control port register access.
    input  wire logic       reg_write,
    input  wire logic       reg_read,
    input  wire logic [7:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    output logic      [7:0] reg_rdata,
    // Interrupt masks, 1 means unmasked.
    input  wire logic [7:0] irq_unmask,
    // Fault and event sources.
    input  wire logic [1:0] adc_fault,
    input  wire logic       mic_bias_fault,
    input  wire logic [1:0] out_guard_fault,
    input  wire logic [1:0] out_short_fault,
    input  wire logic       out_powering_up,
    input  wire logic       reg_short_fault,
    input  wire logic [1:0] aux_event,
    input  wire logic [1:0] adc_overload_recovery,
    // Host recovery requests for manual mode.
    input  wire logic       adc_restart,
    input  wire logic       out_restart,
    // Power-down, mute and interrupt outputs.
    output logic      [1:0] adc_powerdown,
    output logic            mic_bias_powerdown,
    output logic      [1:0] out_powerdown,
    output logic      [1:0] adc_mute,
    output logic            irq_out
);

    typedef struct packed {
        logic [7:0] irq_cfg;
        logic [1:0] out_pd_sel;
        logic       out_recovery;
        logic       guard_inhibit;
        logic       out_det_dis;
        logic       reg_det_dis;
        logic [2:0] mute_rsv;
        logic       ch1_mute_en;
        logic       ch2_mute_en;
        logic [7:0] sticky;
        logic [7:0] live_d;
        logic [1:0] adc_down;
        logic       bias_down;
        logic [1:0] out_down;
        logic [1:0] mute;
        logic       irq;
        logic [7:0] rdata;
    } cifp_state_t;

    cifp_state_t state;
    cifp_state_t next_state;

    // Power-down request for one source under a select code.
    function automatic logic pd_request(input logic [1:0] sel,
                                        input logic       fault,
                                        input logic       unmasked);
        logic req;
        req = 1'b0;
        if (sel == cifp_pkg::PD_SEL_UNMASKED)
        begin
            req = fault & unmasked;
        end
        else if (sel == cifp_pkg::PD_SEL_ALL)
        begin
            req = fault;
        end
        return req;
    endfunction

    // Next power-down state; a new request wins over any recovery.
    function automatic logic pd_next(input logic down,
                                     input logic req,
                                     input logic fault,
                                     input logic manual,
                                     input logic restart);
        logic nxt;
        nxt = down;
        if (req)
        begin
            nxt = 1'b1;
        end
        else if (down && !fault && (!manual || restart))
        begin
            nxt = 1'b0;
        end
        return nxt;
    endfunction

    logic [7:0]               live;
    logic [1:0]               out_fault;
    logic [1:0]               out_pd_src;
    logic                     any_latched;
    logic                     new_event;
    logic                     tmr_enable;
    logic                     tmr_restart;
    logic                     tmr_wrap;
    logic                     tmr_running;
    logic                     tmr_active;
    logic                     irq_assert;
    logic [7:0]               clear_mask;
    logic [7:0]               sticky_view;
    logic [1:0]               adc_sel;
    cifp_pkg::cifp_irq_mode_t mode;

    assign adc_sel = state.irq_cfg[cifp_pkg::ADC_PD_SEL_MSB:
                                   cifp_pkg::ADC_PD_SEL_LSB];
    assign mode = cifp_pkg::cifp_irq_mode_t'(
                  state.irq_cfg[cifp_pkg::IRQ_MODE_MSB:
                                cifp_pkg::IRQ_MODE_LSB]);

    // Output faults are gated by the detect disable.
    assign out_fault = (out_guard_fault | out_short_fault)
                     & {2{~state.out_det_dis}};

    // A guard fault while powering up may be kept from powering down.
    assign out_pd_src = (out_short_fault
                      | (out_guard_fault
                      & {2{~(out_powering_up & state.guard_inhibit)}}))
                      & {2{~state.out_det_dis}};

    always_comb
    begin
        live = '0;
        live[cifp_pkg::EV_ADC_CH1]   = adc_fault[0];
        live[cifp_pkg::EV_ADC_CH2]   = adc_fault[1];
        live[cifp_pkg::EV_MIC_BIAS]  = mic_bias_fault;
        live[cifp_pkg::EV_OUT_CH1]   = out_fault[0];
        live[cifp_pkg::EV_OUT_CH2]   = out_fault[1];
        live[cifp_pkg::EV_REG_SHORT] = reg_short_fault
                                     & ~state.reg_det_dis;
        live[cifp_pkg::EV_AUX_MSB:cifp_pkg::EV_AUX_LSB] = aux_event;
    end

    assign any_latched = |(state.sticky & irq_unmask);
    assign new_event   = |(live & ~state.live_d & irq_unmask);

    // Only the timed modes run the timer, so it idles otherwise.
    always_comb
    begin
        tmr_enable  = 1'b0;
        tmr_restart = 1'b0;
        tmr_wrap    = 1'b0;
        unique case (mode)
            cifp_pkg::CIFP_IRQ_LATCHED:
            begin
                tmr_enable = 1'b0;
            end
            cifp_pkg::CIFP_IRQ_LIVE:
            begin
                tmr_enable = 1'b0;
            end
            cifp_pkg::CIFP_IRQ_REPEAT:
            begin
                tmr_enable  = any_latched;
                tmr_restart = any_latched & ~tmr_running;
                tmr_wrap    = 1'b1;
            end
            cifp_pkg::CIFP_IRQ_ONE_SHOT:
            begin
                tmr_enable  = 1'b1;
                tmr_restart = new_event;
                tmr_wrap    = 1'b0;
            end
        endcase
    end

    cifp_pulse_timer #(
        .PULSE_CYCLES  (PULSE_CYCLES),
        .PERIOD_CYCLES (PERIOD_CYCLES)
    ) u_timer (
        .clk     (clk),
        .reset   (reset),
        .enable  (tmr_enable),
        .restart (tmr_restart),
        .wrap    (tmr_wrap),
        .running (tmr_running),
        .active  (tmr_active)
    );

    always_comb
    begin
        irq_assert = 1'b0;
        unique case (mode)
            cifp_pkg::CIFP_IRQ_LATCHED:
            begin
                irq_assert = any_latched;
            end
            cifp_pkg::CIFP_IRQ_LIVE:
            begin
                irq_assert = |(live & irq_unmask);
            end
            cifp_pkg::CIFP_IRQ_REPEAT:
            begin
                irq_assert = tmr_active;
            end
            cifp_pkg::CIFP_IRQ_ONE_SHOT:
            begin
                irq_assert = tmr_active;
            end
        endcase
    end

    // Policy 0 keeps a flag whose condition is still live.
    assign clear_mask = state.irq_cfg[cifp_pkg::CLEAR_POLICY_BIT]
                      ? 8'hFF : ~live;
    assign sticky_view = state.irq_cfg[cifp_pkg::READBACK_FILT_BIT]
                       ? (state.sticky & irq_unmask)
                       : state.sticky;

    always_comb
    begin
        next_state = state;
        next_state.live_d = live;

        // Register writes; reserved read-only bits keep their reset value.
        if (reg_write)
        begin
            if (reg_addr == cifp_pkg::ADDR_IRQ_CONFIG)
            begin
                next_state.irq_cfg = reg_wdata;
            end
            else if (reg_addr == cifp_pkg::ADDR_OUTPUT_FAULT_CONFIG)
            begin
                next_state.out_pd_sel = reg_wdata[cifp_pkg::OUT_PD_SEL_MSB:
                                                  cifp_pkg::OUT_PD_SEL_LSB];
                next_state.out_recovery =
                    reg_wdata[cifp_pkg::OUT_RECOVERY_BIT];
                next_state.guard_inhibit =
                    reg_wdata[cifp_pkg::GUARD_INHIBIT_BIT];
                next_state.out_det_dis = reg_wdata[cifp_pkg::OUT_DET_DIS_BIT];
                next_state.reg_det_dis = reg_wdata[cifp_pkg::REG_DET_DIS_BIT];
            end
            else if (reg_addr == cifp_pkg::ADDR_OVERLOAD_MUTE_CONFIG)
            begin
                next_state.mute_rsv = reg_wdata[cifp_pkg::MUTE_RSV_MSB:
                                                cifp_pkg::MUTE_RSV_LSB];
                next_state.ch1_mute_en = reg_wdata[cifp_pkg::CH1_MUTE_BIT];
                next_state.ch2_mute_en = reg_wdata[cifp_pkg::CH2_MUTE_BIT];
            end
        end

        // Reads capture data; unmapped addresses read as zero.
        if (reg_read)
        begin
            next_state.rdata = 8'h00;
            if (reg_addr == cifp_pkg::ADDR_IRQ_CONFIG)
            begin
                next_state.rdata = state.irq_cfg;
            end
            else if (reg_addr == cifp_pkg::ADDR_OUTPUT_FAULT_CONFIG)
            begin
                next_state.rdata[cifp_pkg::OUT_PD_SEL_MSB:
                                 cifp_pkg::OUT_PD_SEL_LSB] = state.out_pd_sel;
                next_state.rdata[cifp_pkg::OUT_RECOVERY_BIT] =
                    state.out_recovery;
                next_state.rdata[cifp_pkg::OUT_DOWN_STS_BIT] =
                    |state.out_down;
                next_state.rdata[cifp_pkg::GUARD_INHIBIT_BIT] =
                    state.guard_inhibit;
                next_state.rdata[cifp_pkg::OUT_DET_DIS_BIT] =
                    state.out_det_dis;
                next_state.rdata[cifp_pkg::REG_DET_DIS_BIT] =
                    state.reg_det_dis;
            end
            else if (reg_addr == cifp_pkg::ADDR_OVERLOAD_MUTE_CONFIG)
            begin
                next_state.rdata[cifp_pkg::MUTE_RSV_MSB:
                                 cifp_pkg::MUTE_RSV_LSB] = state.mute_rsv;
                next_state.rdata[cifp_pkg::CH1_MUTE_BIT] = state.ch1_mute_en;
                next_state.rdata[cifp_pkg::CH2_MUTE_BIT] = state.ch2_mute_en;
            end
            else if (reg_addr == cifp_pkg::ADDR_STICKY_FLAG_REGS)
            begin
                next_state.rdata = sticky_view;
            end
            else if (reg_addr == cifp_pkg::ADDR_LIVE_STATUS)
            begin
                next_state.rdata = live;
            end
        end

        // A live condition in the clearing cycle wins over the clear.
        if (reg_read && reg_addr == cifp_pkg::ADDR_STICKY_FLAG_REGS)
        begin
            next_state.sticky = (state.sticky & ~clear_mask)
                              | live;
        end
        else
        begin
            next_state.sticky = state.sticky | live;
        end

        // Power-down of ADC channels and bias shares one select.
        next_state.adc_down[0] = pd_next(state.adc_down[0],
            pd_request(adc_sel, adc_fault[0],
                       irq_unmask[cifp_pkg::EV_ADC_CH1]),
            adc_fault[0], state.irq_cfg[cifp_pkg::ADC_RECOVERY_BIT],
            adc_restart);
        next_state.adc_down[1] = pd_next(state.adc_down[1],
            pd_request(adc_sel, adc_fault[1],
                       irq_unmask[cifp_pkg::EV_ADC_CH2]),
            adc_fault[1], state.irq_cfg[cifp_pkg::ADC_RECOVERY_BIT],
            adc_restart);
        next_state.bias_down = pd_next(state.bias_down,
            pd_request(adc_sel, mic_bias_fault,
                       irq_unmask[cifp_pkg::EV_MIC_BIAS]),
            mic_bias_fault, state.irq_cfg[cifp_pkg::ADC_RECOVERY_BIT],
            adc_restart);

        // Output channels; recovery waits for the whole fault to clear.
        next_state.out_down[0] = pd_next(state.out_down[0],
            pd_request(state.out_pd_sel, out_pd_src[0],
                       irq_unmask[cifp_pkg::EV_OUT_CH1]),
            out_fault[0], state.out_recovery,
            out_restart);
        next_state.out_down[1] = pd_next(state.out_down[1],
            pd_request(state.out_pd_sel, out_pd_src[1],
                       irq_unmask[cifp_pkg::EV_OUT_CH2]),
            out_fault[1], state.out_recovery,
            out_restart);

        next_state.mute[0] = state.ch1_mute_en
                           & adc_overload_recovery[0];
        next_state.mute[1] = state.ch2_mute_en
                           & adc_overload_recovery[1];

        next_state.irq = state.irq_cfg[cifp_pkg::IRQ_POLARITY_BIT]
                       ? irq_assert : ~irq_assert;
    end

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            state               <= '0;
            state.irq_cfg       <= cifp_pkg::RST_IRQ_CONFIG;
            state.out_pd_sel    <= cifp_pkg::RST_OUTPUT_FAULT_CONFIG[
                                   cifp_pkg::OUT_PD_SEL_MSB:
                                   cifp_pkg::OUT_PD_SEL_LSB];
            state.out_recovery  <= cifp_pkg::RST_OUTPUT_FAULT_CONFIG[
                                   cifp_pkg::OUT_RECOVERY_BIT];
            state.guard_inhibit <= cifp_pkg::RST_OUTPUT_FAULT_CONFIG[
                                   cifp_pkg::GUARD_INHIBIT_BIT];
            state.out_det_dis   <= cifp_pkg::RST_OUTPUT_FAULT_CONFIG[
                                   cifp_pkg::OUT_DET_DIS_BIT];
            state.reg_det_dis   <= cifp_pkg::RST_OUTPUT_FAULT_CONFIG[
                                   cifp_pkg::REG_DET_DIS_BIT];
            state.mute_rsv      <= cifp_pkg::RST_OVERLOAD_MUTE_CONFIG[
                                   cifp_pkg::MUTE_RSV_MSB:
                                   cifp_pkg::MUTE_RSV_LSB];
            // Active-low default polarity means the idle pin is high.
            state.irq           <= 1'b1;
        end
        else
        begin
            state <= next_state;
        end
    end

    assign reg_rdata          = state.rdata;
    assign adc_powerdown      = state.adc_down;
    assign mic_bias_powerdown = state.bias_down;
    assign out_powerdown      = state.out_down;
    assign adc_mute           = state.mute;
    assign irq_out            = state.irq;

endmodule

//--- hw/cifp_pkg.sv
// Package of register map, field layout, reset values and timing constants.
package cifp_pkg;

    // Register addresses on the control port.
    localparam logic [7:0] ADDR_IRQ_CONFIG           = 8'h42;
    localparam logic [7:0] ADDR_OUTPUT_FAULT_CONFIG  = 8'h43;
    localparam logic [7:0] ADDR_OVERLOAD_MUTE_CONFIG = 8'h4B;
    localparam logic [7:0] ADDR_STICKY_FLAG_REGS     = 8'h3C;
    localparam logic [7:0] ADDR_LIVE_STATUS          = 8'h3D;

    // Reset values.
    localparam logic [7:0] RST_IRQ_CONFIG           = 8'h00;
    localparam logic [7:0] RST_OUTPUT_FAULT_CONFIG  = 8'h50;
    localparam logic [7:0] RST_OVERLOAD_MUTE_CONFIG = 8'h00;

    // Field positions of irq_config.
    localparam int unsigned IRQ_POLARITY_BIT   = 7;
    localparam int unsigned IRQ_MODE_MSB       = 6;
    localparam int unsigned IRQ_MODE_LSB       = 5;
    localparam int unsigned ADC_PD_SEL_MSB     = 4;
    localparam int unsigned ADC_PD_SEL_LSB     = 3;
    localparam int unsigned READBACK_FILT_BIT  = 2;
    localparam int unsigned ADC_RECOVERY_BIT   = 1;
    localparam int unsigned CLEAR_POLICY_BIT   = 0;

    // Field positions of output_fault_config.
    localparam int unsigned OUT_PD_SEL_MSB     = 6;
    localparam int unsigned OUT_PD_SEL_LSB     = 5;
    localparam int unsigned OUT_RECOVERY_BIT   = 4;
    localparam int unsigned OUT_DOWN_STS_BIT   = 3;
    localparam int unsigned GUARD_INHIBIT_BIT  = 2;
    localparam int unsigned OUT_DET_DIS_BIT    = 1;
    localparam int unsigned REG_DET_DIS_BIT    = 0;

    // Field positions of overload_mute_config.
    localparam int unsigned MUTE_RSV_MSB       = 7;
    localparam int unsigned MUTE_RSV_LSB       = 5;
    localparam int unsigned CH1_MUTE_BIT       = 4;
    localparam int unsigned CH2_MUTE_BIT       = 3;

    // Event positions in the live and sticky vectors.
    localparam int unsigned EV_COUNT     = 8;
    localparam int unsigned EV_ADC_CH1   = 0;
    localparam int unsigned EV_ADC_CH2   = 1;
    localparam int unsigned EV_MIC_BIAS  = 2;
    localparam int unsigned EV_OUT_CH1   = 3;
    localparam int unsigned EV_OUT_CH2   = 4;
    localparam int unsigned EV_REG_SHORT = 5;
    localparam int unsigned EV_AUX_LSB   = 6;
    localparam int unsigned EV_AUX_MSB   = 7;

    // Timing of the pulsed interrupt modes.
    localparam int unsigned CLK_FREQ_KHZ       = 50000;
    localparam int unsigned IRQ_PULSE_MS       = 2;
    localparam int unsigned IRQ_PERIOD_MS      = 4;
    localparam int unsigned IRQ_PULSE_CYCLES   = IRQ_PULSE_MS * CLK_FREQ_KHZ;
    localparam int unsigned IRQ_PERIOD_CYCLES  = IRQ_PERIOD_MS * CLK_FREQ_KHZ;

    // Interrupt output modes.
    typedef enum logic [1:0] {
        CIFP_IRQ_LATCHED  = 2'b00,
        CIFP_IRQ_LIVE     = 2'b01,
        CIFP_IRQ_REPEAT   = 2'b10,
        CIFP_IRQ_ONE_SHOT = 2'b11
    } cifp_irq_mode_t;

    // Fault power-down selections.
    localparam logic [1:0] PD_SEL_NONE     = 2'h0;
    localparam logic [1:0] PD_SEL_UNMASKED = 2'h1;
    localparam logic [1:0] PD_SEL_ALL      = 2'h2;

endpackage

//--- hw/cifp_pulse_timer.sv
// Pulse and period timer that shapes the interrupt output in timed modes.
`timescale 1ns/1ps

module cifp_pulse_timer #(
    parameter int unsigned PULSE_CYCLES  = cifp_pkg::IRQ_PULSE_CYCLES,
    parameter int unsigned PERIOD_CYCLES = cifp_pkg::IRQ_PERIOD_CYCLES
) (
    // Clock and reset.
    input  wire logic clk,
    input  wire logic reset,
    // Control.
    input  wire logic enable,
    input  wire logic restart,
    input  wire logic wrap,
    // Status.
    output logic      running,
    output logic      active
);

    localparam int unsigned CW = $clog2(PERIOD_CYCLES);
    localparam logic [CW-1:0] LAST = CW'(PERIOD_CYCLES - 1);
    localparam logic [CW-1:0] HIGH = CW'(PULSE_CYCLES);

    if (PULSE_CYCLES < 1 || PERIOD_CYCLES <= PULSE_CYCLES)
    begin : g_check
        $error("Pulse must be at least one cycle and shorter than period.");
    end

    typedef struct packed {
        logic [CW-1:0] count;
        logic          run;
    } cifp_timer_state_t;

    cifp_timer_state_t state;
    cifp_timer_state_t next_state;

    always_comb
    begin
        next_state = state;
        if (!enable)
        begin
            next_state.run   = 1'b0;
            next_state.count = '0;
        end
        else if (restart)
        begin
            next_state.run   = 1'b1;
            next_state.count = '0;
        end
        else if (state.run)
        begin
            if (state.count == LAST)
            begin
                next_state.count = '0;
                next_state.run   = wrap;
            end
            else
            begin
                next_state.count = state.count + CW'(1);
            end
        end
    end

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            state <= '0;
        end
        else
        begin
            state <= next_state;
        end
    end

    assign running = state.run;
    assign active  = state.run && (state.count < HIGH);

endmodule

//--- sim/cifp_irq_fault_cfg_properties.sv
// Checker of port relations of the interrupt and fault block.
`timescale 1ns/1ps
module cifp_irq_fault_cfg_properties (
    // Clock, reset and register port.
    input wire logic       clk,
    input wire logic       reset,
    input wire logic       reg_write,
    input wire logic       reg_read,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata,
    // Sources and outputs.
    input wire logic [1:0] adc_fault,
    input wire logic [1:0] out_short_fault,
    input wire logic [1:0] adc_overload_recovery,
    input wire logic       adc_restart,
    input wire logic [1:0] adc_powerdown,
    input wire logic [1:0] out_powerdown,
    input wire logic [1:0] adc_mute
);
    // Shadow copies; read-only bits are never consulted.
    logic [7:0] r42;
    logic [7:0] r43;
    logic [7:0] r4b;
    always_ff @(posedge clk)
    begin
        if (reset)
            {r42, r43, r4b} <= 24'h005000;
        else if (reg_write && reg_addr == 8'h42)
            r42 <= reg_wdata;
        else if (reg_write && reg_addr == 8'h43)
            r43 <= reg_wdata;
        else if (reg_write && reg_addr == 8'h4B)
            r4b <= reg_wdata;
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    mute_ch1_a: assert property (adc_mute[0] ==
        $past(r4b[4] & adc_overload_recovery[0])) else $error("ch1 mute");
    mute_ch2_a: assert property (adc_mute[1] ==
        $past(r4b[3] & adc_overload_recovery[1])) else $error("ch2 mute");
    adc_pd_all_a: assert property (adc_fault[0] && r42[4:3] == 2'h2
        |=> adc_powerdown[0]) else $error("adc not powered down");
    adc_pd_none_a: assert property (r42[4:3] == 2'h0 &&
        !adc_powerdown[1] |=> !adc_powerdown[1]) else $error("adc down");
    auto_recover_a: assert property (adc_powerdown[0] &&
        !adc_fault[0] && !r42[1] |=> !adc_powerdown[0]) else $error("no up");
    manual_hold_a: assert property (adc_powerdown[0] && r42[1] &&
        !adc_restart |=> adc_powerdown[0]) else $error("adc left down");
    out_short_pd_a: assert property (out_short_fault[0] &&
        r43[6:5] == 2'h2 && !r43[1] |=> out_powerdown[0]) else $error("out");
    out_det_off_a: assert property (r43[1] && !out_powerdown[1]
        |=> !out_powerdown[1]) else $error("out fault not ignored");
    down_status_a: assert property (reg_read && reg_addr == 8'h43
        |=> reg_rdata[3] == $past(|out_powerdown)) else $error("status");
    cover property ($rose(adc_powerdown[0]));
    cover property ($rose(out_powerdown[0]));
    cover property (adc_mute == 2'h3);
endmodule

//--- sim/cifp_host_model.sv
// Host side model that reads the interrupt pin and times its assertion.
`timescale 1ns/1ps
module cifp_host_model (
    // Clock and pin.
    input  wire logic        clk,
    input  wire logic        irq_out,
    // Host view.
    input  wire logic        polarity,
    input  wire logic        clr,
    output logic      [15:0] seen
);
    // The host knows the polarity it programmed; the pin alone does not.
    always_ff @(posedge clk)
    begin
        if (clr)
            seen <= 16'h0000;
        else if (irq_out == polarity)
            seen <= seen + 16'h0001;
    end
endmodule

//--- sim/cifp_irq_fault_cfg_tb.sv
// Self-checking bench of the interrupt and fault configuration block.
`timescale 1ns/1ps
module cifp_irq_fault_cfg_tb;
    logic        clk = 1'b0, reset = 1'b1, reg_write = 1'b0, reg_read = 1'b0;
    logic        out_powering_up = 1'b0, adc_restart = 1'b0, pol = 1'b0;
    logic        out_restart = 1'b0, host_clr = 1'b0, mic_bias_fault = 1'b0;
    logic        reg_short_fault = 1'b0;
    logic [7:0]  reg_addr = 8'h00, reg_wdata = 8'h00, irq_unmask = 8'hFF;
    logic [1:0]  adc_fault = 2'h0, out_guard_fault = 2'h0, aux_event = 2'h0;
    logic [1:0]  out_short_fault = 2'h0, adc_overload_recovery = 2'h0;
    logic [7:0]  reg_rdata, m;
    logic [1:0]  adc_powerdown, out_powerdown, adc_mute;
    logic        mic_bias_powerdown, irq_out;
    logic [15:0] irq_seen;
    int          n_mismatch = 0, samples_checked = 0, seed = 32'h53D88EFF;
    always #10 clk = ~clk;
    cifp_irq_fault_cfg #(.PULSE_CYCLES(4), .PERIOD_CYCLES(8)) uut (.clk,
        .reset, .reg_write, .reg_read, .reg_addr, .reg_wdata, .reg_rdata,
        .irq_unmask, .adc_fault, .mic_bias_fault, .out_guard_fault,
        .out_short_fault, .out_powering_up, .reg_short_fault,
        .aux_event, .adc_overload_recovery, .adc_restart, .out_restart,
        .adc_powerdown, .mic_bias_powerdown, .out_powerdown, .adc_mute,
        .irq_out);
    cifp_host_model host (.clk, .irq_out, .polarity(pol), .clr(host_clr),
        .seen(irq_seen));
    task automatic chk(input string nm, input logic [15:0] e, g);
        samples_checked++;
        if (g !== e)
        begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic wr(input logic [7:0] a, d);
        @(negedge clk);
        {reg_write, reg_addr, reg_wdata} = {1'b1, a, d};
        @(negedge clk);
        reg_write = 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, e);
        @(negedge clk);
        {reg_read, reg_addr} = {1'b1, a};
        @(negedge clk);
        reg_read = 1'b0;
        chk("reg_rdata", {8'h00, e}, {8'h00, reg_rdata});
    endtask
    task automatic irq(input logic e, input int n);
        repeat (n) @(negedge clk);
        chk("irq_out", {15'h0, e}, {15'h0, irq_out});
    endtask
    task automatic print_verdict;
        $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    initial
    begin
        repeat (3) @(negedge clk);
        reset = 1'b0;
        rd(8'h42, 8'h00);
        rd(8'h43, 8'h50);
        wr(8'h43, 8'h7F);
        rd(8'h43, 8'h77);
        wr(8'h43, 8'h50);
        aux_event = 2'h1;
        irq(1'b1, 1);
        aux_event = 2'h0;
        irq(1'b0, 2);
        rd(8'h3C, 8'h40);
        rd(8'h3C, 8'h00);
        irq(1'b1, 0);
        {aux_event, irq_unmask} = {2'h2, 8'h7F};
        rd(8'h3C, 8'h80);
        irq(1'b1, 0);
        wr(8'h42, 8'h04);
        rd(8'h3C, 8'h00);
        wr(8'h42, 8'hA0);
        {aux_event, irq_unmask, pol} = {2'h0, 8'hFF, 1'b1};
        irq(1'b0, 1);
        aux_event = 2'h1;
        irq(1'b1, 1);
        wr(8'h42, 8'h40);
        {aux_event, pol, host_clr} = 4'h1;
        repeat (4) @(negedge clk);
        host_clr = 1'b0;
        repeat (32) @(negedge clk);
        chk("irq_seen", 16'd16, irq_seen);
        wr(8'h42, 8'h60);
        {aux_event, host_clr} = 3'h5;
        @(negedge clk);
        host_clr = 1'b0;
        repeat (20) @(negedge clk);
        chk("irq_seen", 16'd4, irq_seen);
        wr(8'h42, 8'h10);
        repeat (4)
        begin
            m = $random(seed) & 8'h18;
            wr(8'h4B, m);
            repeat (8)
            begin
                {mic_bias_fault, adc_fault, adc_overload_recovery} =
                    $random(seed);
                @(negedge clk);
                chk("bias_pd", {15'h0, mic_bias_fault},
                    {15'h0, mic_bias_powerdown});
                chk("adc_pd", {14'h0, adc_fault}, {14'h0, adc_powerdown});
                chk("mute", {14'h0, m[3], m[4]} & {14'h0,
                    adc_overload_recovery}, {14'h0, adc_mute});
            end
        end
        wr(8'h42, 8'h12);
        {mic_bias_fault, adc_fault} = 3'h1;
        @(negedge clk);
        adc_fault = 2'h0;
        repeat (2) @(negedge clk);
        chk("adc_pd", 16'h1, {15'h0, adc_powerdown[0]});
        adc_restart = 1'b1;
        @(negedge clk);
        adc_restart = 1'b0;
        @(negedge clk);
        chk("adc_pd", 16'h0, {14'h0, adc_powerdown});
        out_short_fault = 2'h1;
        @(negedge clk);
        out_short_fault = 2'h0;
        rd(8'h43, 8'h58);
        out_restart = 1'b1;
        @(negedge clk);
        out_restart = 1'b0;
        @(negedge clk);
        chk("out_pd", 16'h0, {14'h0, out_powerdown});
        wr(8'h43, 8'h52);
        {out_guard_fault, out_short_fault} = 4'hF;
        repeat (2) @(negedge clk);
        chk("out_pd", 16'h0, {14'h0, out_powerdown});
        wr(8'h43, 8'h54);
        {out_powering_up, out_short_fault} = 3'h4;
        repeat (2) @(negedge clk);
        chk("out_pd", 16'h0, {14'h0, out_powerdown});
        out_powering_up = 1'b0;
        repeat (2) @(negedge clk);
        chk("out_pd", 16'h3, {14'h0, out_powerdown});
        reg_short_fault = 1'b1;
        rd(8'h3D, 8'hB8);
        wr(8'h43, 8'h55);
        rd(8'h3D, 8'h98);
        print_verdict();
    end
    initial
    begin
        repeat (5000) @(posedge clk);
        n_mismatch++;
        print_verdict();
    end
endmodule
bind cifp_irq_fault_cfg cifp_irq_fault_cfg_properties chk_i (.clk, .reset,
    .reg_write, .reg_read, .reg_addr, .reg_wdata, .reg_rdata, .adc_fault,
    .out_short_fault, .adc_overload_recovery, .adc_restart, .adc_powerdown,
    .out_powerdown, .adc_mute);
